// ---- frc_fault_retry.sv ----
`timescale 1ns/1ns
`include "frc_regs.svh"

module frc_fault_retry
  import frc_pkg::*;
#(
  parameter int TICK_W = 16
) (
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic [TICK_W-1:0] UNIT_TICKS_I,
  input wire logic [15:0] VOUT_MEAS_I,
  input wire logic CLEAR_FAULT_I,
  input wire logic OV_FAULT_I,
  input wire logic ON_CMD_I,
  input wire logic BIAS_OK_I,
  input wire logic OTHER_FAULT_I,
  output logic OUTPUT_EN_O,
  output logic OV_WARN_O,
  output logic LATCHED_O
);

  logic [7:0] overvoltage_fault_reaction;
  logic [15:0] output_overvoltage_warning_threshold;
  logic [3:0] sync1;
  logic [3:0] sync2;
  frc_state_t state;
  frc_state_t next_state;
  logic [2:0] retry_left;
  logic [2:0] next_retry_left;
  logic timer_start;
  logic timer_done;

  // the OV, on, bias and other-fault pins pass two flops before use
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {OTHER_FAULT_I, BIAS_OK_I, ON_CMD_I, OV_FAULT_I};
      sync2 <= sync1;
    end
  end

  wire logic fault = sync2[0];
  wire logic stop_req = !sync2[1] || !sync2[2] || sync2[3];

  wire logic [1:0] resp =
    overvoltage_fault_reaction[`FRC_RESP_HI:`FRC_RESP_LO];
  wire logic [2:0] retries =
    overvoltage_fault_reaction[`FRC_RETRY_HI:`FRC_RETRY_LO];
  wire logic [2:0] delay_code =
    overvoltage_fault_reaction[`FRC_DELAY_HI:`FRC_DELAY_LO];
  wire logic forever_mode = (retries == `FRC_RETRY_FOREVER);

  wire logic wr_react = REG_WR_I && (REG_ADDR_I == `FRC_ADDR_REACTION);
  wire logic wr_warn = REG_WR_I && (REG_ADDR_I == `FRC_ADDR_WARN_THRESH);
  wire logic rd_react = REG_ADDR_I == `FRC_ADDR_REACTION;
  wire logic rd_warn = REG_ADDR_I == `FRC_ADDR_WARN_THRESH;
  // unmapped codes read as zero
  wire logic [15:0] rd_mux =
    rd_warn ? output_overvoltage_warning_threshold :
    rd_react ? {8'h00, overvoltage_fault_reaction} : 16'h0000;

  // threshold is compared raw: both sides share the same scaling
  wire logic warn_now = VOUT_MEAS_I > output_overvoltage_warning_threshold;

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      overvoltage_fault_reaction <= `FRC_RST_REACTION;
      output_overvoltage_warning_threshold <= `FRC_RST_WARN_THRESH;
    end else begin
      if (wr_react)
        overvoltage_fault_reaction <= REG_WDATA_I[7:0];
      if (wr_warn)
        output_overvoltage_warning_threshold <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REG_RDATA_O <= 16'h0000;
      OV_WARN_O <= 1'b0;
    end else begin
      if (REG_RD_I)
        REG_RDATA_O <= rd_mux;
      OV_WARN_O <= warn_now;
    end
  end

  frc_delay_timer #(
    .TICK_W(TICK_W)
  ) u_timer (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .start_i(timer_start),
    .code_i(delay_code),
    .unit_ticks_i(UNIT_TICKS_I),
    .done_o(timer_done)
  );

  // shutdown action shared by mode 10 and an expired run-on delay
  wire frc_state_t shut_state =
    (retries == `FRC_RETRY_NONE) ? FRC_ST_LATCH : FRC_ST_WAIT;
  wire logic shut_timer = (retries != `FRC_RETRY_NONE);

  always_comb begin
    next_state = state;
    next_retry_left = retry_left;
    timer_start = 1'b0;
    unique case (state)
      FRC_ST_RUN: begin
        if (stop_req) begin
          next_state = FRC_ST_STOP;
        end else if (fault) begin
          unique case (resp)
            `FRC_RESP_IGNORE: next_state = FRC_ST_RUN;
            `FRC_RESP_CONTINUE: begin
              next_state = FRC_ST_CONT;
              timer_start = 1'b1;
            end
            `FRC_RESP_RETRY: begin
              next_state = shut_state;
              next_retry_left = retries;
              timer_start = shut_timer;
            end
            `FRC_RESP_RESUME: next_state = FRC_ST_HOLD;
          endcase
        end
      end
      FRC_ST_CONT: begin
        if (stop_req) begin
          next_state = FRC_ST_STOP;
        end else if (timer_done) begin
          next_state = fault ? shut_state : FRC_ST_RUN;
          next_retry_left = retries;
          timer_start = fault && shut_timer;
        end
      end
      FRC_ST_HOLD: begin
        if (stop_req)
          next_state = FRC_ST_STOP;
        else if (!fault)
          next_state = FRC_ST_RUN;
      end
      FRC_ST_WAIT: begin
        if (stop_req) begin
          next_state = FRC_ST_STOP;
        end else if (timer_done) begin
          next_state = FRC_ST_RETRY;
          timer_start = 1'b1;
        end
      end
      FRC_ST_RETRY: begin
        if (stop_req) begin
          next_state = FRC_ST_STOP;
        end else if (fault) begin
          // the timer keeps running: spacing is start to start
          // a done swallowed here would leave the wait with no timer
          timer_start = timer_done;
          if (!forever_mode && retry_left == `FRC_RETRY_ONE)
            next_state = FRC_ST_LATCH;
          else
            next_state = FRC_ST_WAIT;
          if (!forever_mode)
            next_retry_left = retry_left - `FRC_RETRY_ONE;
        end else if (timer_done) begin
          next_state = FRC_ST_RUN;
        end
      end
      FRC_ST_LATCH: begin
        if (CLEAR_FAULT_I)
          next_state = FRC_ST_RUN;
      end
      FRC_ST_STOP: begin
        if (!stop_req)
          next_state = FRC_ST_RUN;
      end
      default: next_state = FRC_ST_LATCH;
    endcase
  end

  wire logic next_out_en = (next_state == FRC_ST_RUN) ||
    (next_state == FRC_ST_CONT) || (next_state == FRC_ST_RETRY);

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= FRC_ST_STOP;
      retry_left <= `FRC_RETRY_NONE;
      OUTPUT_EN_O <= 1'b0;
      LATCHED_O <= 1'b0;
    end else begin
      state <= next_state;
      retry_left <= next_retry_left;
      OUTPUT_EN_O <= next_out_en;
      LATCHED_O <= (next_state == FRC_ST_LATCH);
    end
  end

  a_ignore_keeps_on: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    state == FRC_ST_RUN && fault && !stop_req && resp == `FRC_RESP_IGNORE
    |=> OUTPUT_EN_O && state == FRC_ST_RUN)
    else $error("ignored fault disturbed the output");

  a_runon_stays_on: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    state == FRC_ST_CONT |-> OUTPUT_EN_O)
    else $error("output dropped during run-on delay");

  a_disable_shuts: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    state == FRC_ST_RUN && fault && !stop_req && resp == `FRC_RESP_RETRY
    |=> !OUTPUT_EN_O)
    else $error("disable response kept output on");

  a_resume_ok: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    state == FRC_ST_HOLD && !fault && !stop_req
    |=> OUTPUT_EN_O && state == FRC_ST_RUN)
    else $error("output not resumed after fault cleared");

  a_no_retry_latch: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    state == FRC_ST_RUN && fault && !stop_req &&
    resp == `FRC_RESP_RETRY && retries == `FRC_RETRY_NONE
    |=> LATCHED_O && !OUTPUT_EN_O)
    else $error("no-retry setting did not latch off");

  a_count_out: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    state == FRC_ST_RETRY && fault && !stop_req && !forever_mode &&
    retry_left == `FRC_RETRY_ONE |=> LATCHED_O)
    else $error("last failed retry did not latch off");

  a_forever_no_latch: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    state == FRC_ST_RETRY && forever_mode |=> !LATCHED_O)
    else $error("continuous retry latched off");

  a_latch_holds: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    LATCHED_O && !CLEAR_FAULT_I |=> LATCHED_O && !OUTPUT_EN_O)
    else $error("latched-off state left without clear");

  a_warn_flag: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    warn_now |=> OV_WARN_O)
    else $error("warning flag missed");

endmodule

// ---- frc_regs.svh ----
`ifndef FRC_REGS_SVH
`define FRC_REGS_SVH

// register command codes
`define FRC_ADDR_REACTION 8'h41
`define FRC_ADDR_WARN_THRESH 8'h42

// reset values
`define FRC_RST_REACTION 8'h80
`define FRC_RST_WARN_THRESH 16'hFFFF

// reaction byte fields
`define FRC_RESP_HI 7
`define FRC_RESP_LO 6
`define FRC_RETRY_HI 5
`define FRC_RETRY_LO 3
`define FRC_DELAY_HI 2
`define FRC_DELAY_LO 0

// response and retry codes
`define FRC_RESP_IGNORE 2'h0
`define FRC_RESP_CONTINUE 2'h1
`define FRC_RESP_RETRY 2'h2
`define FRC_RESP_RESUME 2'h3
`define FRC_RETRY_NONE 3'h0
`define FRC_RETRY_ONE 3'h1
`define FRC_RETRY_FOREVER 3'h7

// one delay unit as a count of delay time units
`define FRC_ONE_UNIT 8'h01

`endif

// ---- frc_pkg.sv ----
package frc_pkg;

  typedef enum logic [6:0] {
    FRC_ST_RUN   = 7'b000_0001,
    FRC_ST_CONT  = 7'b000_0010,
    FRC_ST_HOLD  = 7'b000_0100,
    FRC_ST_WAIT  = 7'b000_1000,
    FRC_ST_RETRY = 7'b001_0000,
    FRC_ST_LATCH = 7'b010_0000,
    FRC_ST_STOP  = 7'b100_0000
  } frc_state_t;

endpackage

// ---- frc_delay_timer.sv ----
`timescale 1ns/1ns
`include "frc_regs.svh"

module frc_delay_timer #(
  parameter int TICK_W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [2:0] code_i,
  input wire logic [TICK_W-1:0] unit_ticks_i,
  output logic done_o
);

  localparam int CNT_W = TICK_W + 8;

  logic [CNT_W-1:0] cnt;
  logic busy;
  logic [CNT_W-1:0] elapsed;
  logic [CNT_W-1:0] loaded;

  // units are two to the power of the code
  wire logic [7:0] units = `FRC_ONE_UNIT << code_i;
  wire logic [CNT_W-1:0] product = CNT_W'(units * unit_ticks_i);
  // a zero unit length still gives one cycle, so the sequencer never stalls
  wire logic [CNT_W-1:0] total = (product == '0) ? CNT_W'(1) : product;

  assign done_o = busy && (cnt == CNT_W'(1));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (start_i) begin
      cnt <= total;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - CNT_W'(1);
      busy <= !done_o;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      elapsed <= '0;
      loaded <= '0;
    end else if (start_i) begin
      elapsed <= CNT_W'(1);
      loaded <= total;
    end else begin
      elapsed <= elapsed + CNT_W'(1);
    end
  end

  a_delay_length: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o |-> elapsed == loaded)
    else $error("delay ended at the wrong cycle");

endmodule

// ---- frc_host_model.sv ----
`timescale 1ns/1ns
module frc_host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end

  // one-cycle strobe; released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// ---- frc_fault_retry_tb_top.sv ----
`timescale 1ns/1ns
`include "frc_regs.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module frc_fault_retry_tb_top;
  logic clk, rstn, wr, rd, clr, ov, on, bias, oth, en, warn, latched, en_q;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, vout, v;
  logic [15:0] ticks;
  int err_count, samples_checked, rises, gap, cyc, base, wt;
  int ks[4] = '{0, 1, 3, 6};

  frc_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata));
  frc_fault_retry #(.TICK_W(16)) uut (.CLOCK_I(clk), .RSTN_I(rstn),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .UNIT_TICKS_I(ticks), .VOUT_MEAS_I(vout),
    .CLEAR_FAULT_I(clr), .OV_FAULT_I(ov), .ON_CMD_I(on), .BIAS_OK_I(bias),
    .OTHER_FAULT_I(oth), .OUTPUT_EN_O(en), .OV_WARN_O(warn),
    .LATCHED_O(latched));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // attempt counter and spacing between successive attempt starts
  always @(posedge clk) begin
    if (en === 1'b1 && en_q !== 1'b1) begin
      rises <= rises + 1;
      gap <= cyc;
      cyc <= 1;
    end else begin
      cyc <= cyc + 1;
    end
    en_q <= en;
  end

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, v);
    `CHK("rdata", e, v)
  endtask

  task automatic clear_all();
    ov <= 1'b0;
    cyc_n(4);
    clr <= 1'b1;
    cyc_n(1);
    clr <= 1'b0;
    cyc_n(4);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    rstn = 1'b0; clr = 1'b0; ov = 1'b0; on = 1'b1; bias = 1'b1; oth = 1'b0;
    vout = 16'h1000; ticks = 16'h0002; rises = 0; cyc = 0; gap = 0;
    cyc_n(8);
    rstn <= 1'b1;
    rchk(`FRC_ADDR_REACTION, 16'h0080);
    rchk(`FRC_ADDR_WARN_THRESH, 16'hFFFF);
    rchk(8'h10, 16'h0000);
    host.wr(`FRC_ADDR_WARN_THRESH, 16'h1234);
    rchk(`FRC_ADDR_WARN_THRESH, 16'h1234);
    host.wr(`FRC_ADDR_REACTION, 16'hFF00);
    rchk(`FRC_ADDR_REACTION, 16'h0000);
    vout <= 16'h1235;
    cyc_n(3);
    `CHK("warn", 1'b1, warn)
    `CHK("en", 1'b1, en)
    vout <= 16'h1234;
    cyc_n(3);
    `CHK("warn", 1'b0, warn)
    $display("test regs and warning done");
    base = rises;
    ov <= 1'b1;
    cyc_n(30);
    `CHK("en", 1'b1, en)
    `CHK("attempts", 0, rises - base)
    ov <= 1'b0;
    host.wr(`FRC_ADDR_REACTION, 16'h00C0);
    ov <= 1'b1;
    cyc_n(4);
    `CHK("en", 1'b0, en)
    `CHK("latched", 1'b0, latched)
    ov <= 1'b0;
    cyc_n(4);
    `CHK("en", 1'b1, en)
    $display("test ignore and resume done");
    // run-on of 2^3 units of 2 cycles: a short fault must not shut down
    host.wr(`FRC_ADDR_REACTION, 16'h0043);
    base = rises;
    ov <= 1'b1;
    cyc_n(4);
    ov <= 1'b0;
    cyc_n(30);
    `CHK("attempts", 0, rises - base)
    `CHK("en", 1'b1, en)
    ov <= 1'b1;
    cyc_n(12);
    `CHK("en", 1'b1, en)
    cyc_n(20);
    `CHK("latched", 1'b1, latched)
    clear_all();
    `CHK("en", 1'b1, en)
    $display("test run-on done");
    for (int i = 0; i < 4; i++) begin
      host.wr(`FRC_ADDR_REACTION, {8'h00, 2'h2, ks[i][2:0], 3'h0});
      base = rises;
      ov <= 1'b1;
      wt = 0;
      while (latched !== 1'b1 && wt < 500) begin
        @(posedge clk);
        wt++;
      end
      // a loop that runs out is caught here as a mismatch
      `CHK("latched", 1'b1, latched)
      `CHK("attempts", ks[i], rises - base)
      cyc_n(6);
      `CHK("en", 1'b0, en)
      clear_all();
      `CHK("en", 1'b1, en)
    end
    $display("test counted retries done");
    host.wr(`FRC_ADDR_REACTION, 16'h00BA);
    base = rises;
    ov <= 1'b1;
    cyc_n(120);
    `CHK("latched", 1'b0, latched)
    `CHK("many", 1'b1, (rises - base) > 7)
    `CHK("gap", 8, gap)
    on <= 1'b0;
    cyc_n(5);
    base = rises;
    cyc_n(40);
    `CHK("en", 1'b0, en)
    `CHK("attempts", 0, rises - base)
    ov <= 1'b0;
    on <= 1'b1;
    cyc_n(6);
    `CHK("en", 1'b1, en)
    // wider unit: four cycles per unit, code 1 gives eight-cycle spacing
    ticks <= 16'h0004;
    host.wr(`FRC_ADDR_REACTION, 16'h00B9);
    base = rises;
    ov <= 1'b1;
    cyc_n(60);
    // without fresh attempts the old gap of 8 would pass unseen
    `CHK("many", 1'b1, (rises - base) > 2)
    `CHK("gap", 8, gap)
    oth <= 1'b1;
    cyc_n(5);
    `CHK("en", 1'b0, en)
    oth <= 1'b0;
    bias <= 1'b0;
    cyc_n(5);
    base = rises;
    cyc_n(20);
    `CHK("attempts", 0, rises - base)
    `CHK("latched", 1'b0, latched)
    ov <= 1'b0;
    bias <= 1'b1;
    cyc_n(6);
    `CHK("en", 1'b1, en)
    $display("test continuous retry done");
    wrap_up();
  end
endmodule
